// [src/icc_input_capture.v]
/*
 input capture control: samples a capture pin, latches a selected timer count into a
 small fifo on configured edges, counts events per interrupt, reports overflow and
 buffer-not-empty. assumes timer counts arrive synchronous to clock, the pin is
 asynchronous, and software uses an axi4-lite master with one access of each kind.
*/
`timescale 1ns/1ps
`include "icc_defs.vh"
`default_nettype none

module icc_input_capture #(
	parameter DEPTH = 4,
	parameter PTRW = 2
) (
	// clock and reset
	input wire clock,
	input wire rst,
	// capture pin, idle indication, timer counts
	input wire capturePin,
	input wire deviceIdle,
	input wire [15:0] timerTwoCount,
	input wire [15:0] timerThreeCount,
	input wire [31:0] wideTimerCount,
	// axi4-lite write address
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	output reg s_axi_awready,
	// axi4-lite write data
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	output reg s_axi_wready,
	// axi4-lite write response
	output reg [1:0] s_axi_bresp,
	output reg s_axi_bvalid,
	input wire s_axi_bready,
	// axi4-lite read address
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	output reg s_axi_arready,
	// axi4-lite read data
	output reg [31:0] s_axi_rdata,
	output reg [1:0] s_axi_rresp,
	output reg s_axi_rvalid,
	input wire s_axi_rready,
	// interrupt
	output reg irq
);

////////////////////////////////////////////////////////////////////////////////
// helpers

// merges written bytes into a 16-bit register under a writable mask
function [15:0] mergeLow;
	input [15:0] old;
	input [31:0] data;
	input [3:0] strb;
	input [15:0] wmask;
	reg [15:0] bytes;
	begin
		bytes = {{8{strb[1]}}, {8{strb[0]}}} & wmask;
		mergeLow = (old & ~bytes) | (data[15:0] & bytes);
	end
endfunction

////////////////////////////////////////////////////////////////////////////////
// registers

reg [15:0] ctrl_ff; // writable control fields
reg [1:0] mask_ff; // interrupt mask
reg [1:0] stat_ff; // sticky interrupt status
reg [31:0] fifo_ff [0:DEPTH-1]; // capture buffer
reg [PTRW-1:0] wrPtr_ff; // next slot to fill
reg [PTRW-1:0] rdPtr_ff; // next slot to read
reg [PTRW:0] level_ff; // entries held
reg ovf_ff; // overflow seen
reg [2:0] pinSync_ff; // pin synchroniser, three stages
reg pinLevel_ff; // filtered pin level
reg altFlip_ff; // alternating mode has moved off the first edge
reg [3:0] prescale_ff; // edge prescaler for modes 4 and 5
reg [1:0] evtCount_ff; // events since last interrupt

wire enabled = ctrl_ff[`ICC_B_ENABLE];
wire [2:0] mode = ctrl_ff[`ICC_B_MODE_HI:`ICC_B_MODE_LO];
wire [1:0] evtPerIrq = ctrl_ff[`ICC_B_EPI_HI:`ICC_B_EPI_LO];

////////////////////////////////////////////////////////////////////////////////
// pin synchroniser and edge detection

// stage one feeds stage two only; level accepted when stages two and three agree
always @(posedge clock) begin
	if (rst) begin
		pinSync_ff <= 3'h0;
		pinLevel_ff <= 1'b0;
	end else begin
		pinSync_ff <= {pinSync_ff[1:0], capturePin};
		if (pinSync_ff[1] == pinSync_ff[2])
			pinLevel_ff <= pinSync_ff[2];
	end
end

wire agreed = (pinSync_ff[1] == pinSync_ff[2]);
wire riseEdge = agreed && pinSync_ff[2] && !pinLevel_ff;
wire fallEdge = agreed && !pinSync_ff[2] && pinLevel_ff;

// unit runs only while enabled and not halted by idle
wire running = enabled && !(ctrl_ff[`ICC_B_IDLE_STOP] && deviceIdle);

// edge qualification per mode
reg capture;
reg prescaleHit;
always @* begin
	capture = 1'b0;
	prescaleHit = 1'b0;
	case (mode)
	`ICC_MODE_ANY: capture = riseEdge || fallEdge;
	`ICC_MODE_FALL: capture = fallEdge;
	`ICC_MODE_RISE: capture = riseEdge;
	`ICC_MODE_RISE4: begin
		prescaleHit = riseEdge && (prescale_ff[1:0] == 2'h3);
		capture = prescaleHit;
	end
	`ICC_MODE_RISE16: begin
		prescaleHit = riseEdge && (prescale_ff == 4'hF);
		capture = prescaleHit;
	end
	// flip flag, not a copied edge: enable and first edge may come in one write
	`ICC_MODE_ALT: capture = (ctrl_ff[`ICC_B_FIRST_EDGE] ^ altFlip_ff) ? riseEdge : fallEdge;
	`ICC_MODE_ANY7: capture = riseEdge || fallEdge;
	default: capture = 1'b0;
	endcase
	capture = capture && running;
end

// selected timer value; source select has no say when wide capture is on
wire [15:0] narrowCount = ctrl_ff[`ICC_B_SRC] ? timerTwoCount : timerThreeCount;
wire [31:0] captureValue = ctrl_ff[`ICC_B_WIDE] ? wideTimerCount : {16'h0000, narrowCount};

// interrupt every 4, 3 or 2 events; code 01 taken as every event
reg [1:0] evtTarget;
always @* begin
	case (evtPerIrq)
	2'h3: evtTarget = 2'h3;
	2'h2: evtTarget = 2'h2;
	2'h0: evtTarget = 2'h1;
	default: evtTarget = 2'h0;
	endcase
end

////////////////////////////////////////////////////////////////////////////////
// axi4-lite handshake state

reg awHeld_ff; // write address taken, waiting for data
reg wHeld_ff; // write data taken, waiting for address
reg [11:0] awAddr_ff;
reg [31:0] wData_ff;
reg [3:0] wStrb_ff;

wire awFire = s_axi_awvalid && s_axi_awready;
wire wFire = s_axi_wvalid && s_axi_wready;
wire [11:0] wrAddr = awHeld_ff ? awAddr_ff : s_axi_awaddr;
wire [31:0] wrData = wHeld_ff ? wData_ff : s_axi_wdata;
wire [3:0] wrStrb = wHeld_ff ? wStrb_ff : s_axi_wstrb;
wire wrGo = (awHeld_ff || awFire) && (wHeld_ff || wFire) && !s_axi_bvalid;
wire arFire = s_axi_arvalid && s_axi_arready;

wire ctrlWrite = wrGo && (wrAddr[11:2] == `ICC_OFF_CTRL >> 2);
wire bufRead = arFire && (s_axi_araddr[11:2] == `ICC_OFF_BUF >> 2) && (level_ff != 0);
wire statRead = arFire && (s_axi_araddr[11:2] == `ICC_OFF_STAT >> 2);

// a write clearing enable resets the unit's capture state
wire disableNow = ctrlWrite && wrStrb[1] && !wrData[`ICC_B_ENABLE];

// write channel: address and data taken in either order, response after both
always @(posedge clock) begin
	if (rst) begin
		s_axi_awready <= 1'b0;
		s_axi_wready <= 1'b0;
		s_axi_bvalid <= 1'b0;
		s_axi_bresp <= `ICC_RESP_OKAY;
		awHeld_ff <= 1'b0;
		wHeld_ff <= 1'b0;
		awAddr_ff <= 12'h000;
		wData_ff <= 32'h00000000;
		wStrb_ff <= 4'h0;
	end else begin
		s_axi_awready <= !awHeld_ff && !awFire && !s_axi_bvalid;
		s_axi_wready <= !wHeld_ff && !wFire && !s_axi_bvalid;
		if (awFire) begin
			awHeld_ff <= 1'b1;
			awAddr_ff <= s_axi_awaddr;
		end
		if (wFire) begin
			wHeld_ff <= 1'b1;
			wData_ff <= s_axi_wdata;
			wStrb_ff <= s_axi_wstrb;
		end
		if (wrGo) begin
			awHeld_ff <= 1'b0;
			wHeld_ff <= 1'b0;
			s_axi_bvalid <= 1'b1;
			// unmapped offsets answer with an error
			if (wrAddr[11:2] == `ICC_OFF_CTRL >> 2 || wrAddr[11:2] == `ICC_OFF_MASK >> 2
				|| wrAddr[11:2] == `ICC_OFF_BUF >> 2 || wrAddr[11:2] == `ICC_OFF_STAT >> 2)
				s_axi_bresp <= `ICC_RESP_OKAY;
			else
				s_axi_bresp <= `ICC_RESP_SLVERR;
		end else if (s_axi_bvalid && s_axi_bready) begin
			s_axi_bvalid <= 1'b0;
		end
	end
end

// read channel: one read at a time, data one cycle after address
always @(posedge clock) begin
	if (rst) begin
		s_axi_arready <= 1'b0;
		s_axi_rvalid <= 1'b0;
		s_axi_rdata <= 32'h00000000;
		s_axi_rresp <= `ICC_RESP_OKAY;
	end else begin
		s_axi_arready <= !s_axi_rvalid && !arFire;
		if (arFire) begin
			s_axi_rvalid <= 1'b1;
			s_axi_rresp <= `ICC_RESP_OKAY;
			case (s_axi_araddr[11:2])
			`ICC_OFF_CTRL >> 2: begin
				// upper half always zero; status bits live here
				s_axi_rdata <= {16'h0000, ctrl_ff[15:5], ovf_ff, (level_ff != 0), ctrl_ff[2:0]};
			end
			`ICC_OFF_BUF >> 2: s_axi_rdata <= fifo_ff[rdPtr_ff];
			`ICC_OFF_STAT >> 2: s_axi_rdata <= {30'h0, stat_ff};
			`ICC_OFF_MASK >> 2: s_axi_rdata <= {30'h0, mask_ff};
			default: begin
				s_axi_rdata <= 32'h00000000;
				s_axi_rresp <= `ICC_RESP_SLVERR;
			end
			endcase
		end else if (s_axi_rvalid && s_axi_rready) begin
			s_axi_rvalid <= 1'b0;
		end
	end
end

////////////////////////////////////////////////////////////////////////////////
// control, mask and capture engine

wire fifoFull = (level_ff == DEPTH);
wire push = capture && !fifoFull;
wire pop = bufRead;

// control and mask registers; upper half of control is never stored
always @(posedge clock) begin
	if (rst) begin
		ctrl_ff <= `ICC_CTRL_RESET;
		mask_ff <= 2'h0;
	end else begin
		if (ctrlWrite)
			ctrl_ff <= mergeLow(ctrl_ff, wrData, wrStrb, `ICC_CTRL_WMASK);
		if (wrGo && wrAddr[11:2] == `ICC_OFF_MASK >> 2 && wrStrb[0])
			mask_ff <= wrData[1:0];
	end
end

// fifo, overflow, edge trackers and event counter
// writing a cleared enable drops all capture state at once; software should not
// touch the registers in the cycle right after that write
always @(posedge clock) begin
	if (rst || !enabled || disableNow) begin
		wrPtr_ff <= {PTRW{1'b0}};
		rdPtr_ff <= {PTRW{1'b0}};
		level_ff <= {(PTRW+1){1'b0}};
		ovf_ff <= 1'b0;
		altFlip_ff <= 1'b0;
		prescale_ff <= 4'h0;
		evtCount_ff <= 2'h0;
	end else begin
		if (push) begin
			fifo_ff[wrPtr_ff] <= captureValue;
			wrPtr_ff <= wrPtr_ff + 1'b1;
		end
		if (pop)
			rdPtr_ff <= rdPtr_ff + 1'b1;
		if (push && !pop)
			level_ff <= level_ff + 1'b1;
		else if (pop && !push)
			level_ff <= level_ff - 1'b1;
		// event on a full buffer is lost and flagged
		if (capture && fifoFull)
			ovf_ff <= 1'b1;
		// alternating mode flips expected edge after each capture
		if (mode != `ICC_MODE_ALT)
			altFlip_ff <= 1'b0;
		else if (capture)
			altFlip_ff <= !altFlip_ff;
		if (running && riseEdge && (mode == `ICC_MODE_RISE4 || mode == `ICC_MODE_RISE16))
			prescale_ff <= prescale_ff + 1'b1;
		if (capture)
			evtCount_ff <= (evtCount_ff >= evtTarget) ? 2'h0 : evtCount_ff + 1'b1;
	end
end

wire irqEvent = capture && (evtCount_ff >= evtTarget);

// sticky status: read clears, new event in same cycle wins; no events while disabled
always @(posedge clock) begin
	if (rst) begin
		stat_ff <= 2'h0;
		irq <= 1'b0;
	end else begin
		stat_ff <= (statRead ? 2'h0 : stat_ff)
			| {capture && fifoFull && enabled, irqEvent && enabled};
		irq <= |(stat_ff & mask_ff) && enabled;
	end
end

endmodule
`default_nettype wire

// [src/icc_defs.vh]
/*
 constants for the input capture control block: register offsets, field positions,
 reset values and mode codes. assumes inclusion by bare name from the design file.
*/
`ifndef ICC_DEFS_VH
`define ICC_DEFS_VH

// register byte offsets
`define ICC_OFF_CTRL 12'h000
`define ICC_OFF_BUF 12'h004
`define ICC_OFF_STAT 12'h008
`define ICC_OFF_MASK 12'h00C

// control register fields
`define ICC_B_ENABLE 15
`define ICC_B_IDLE_STOP 13
`define ICC_B_FIRST_EDGE 9
`define ICC_B_WIDE 8
`define ICC_B_SRC 7
`define ICC_B_EPI_HI 6
`define ICC_B_EPI_LO 5
`define ICC_B_OVF 4
`define ICC_B_BNE 3
`define ICC_B_MODE_HI 2
`define ICC_B_MODE_LO 0

// writable bits and reset value of the control register
`define ICC_CTRL_WMASK 16'hA3E7
`define ICC_CTRL_RESET 16'h0000

// capture mode codes
`define ICC_MODE_OFF 3'h0
`define ICC_MODE_ANY 3'h1
`define ICC_MODE_FALL 3'h2
`define ICC_MODE_RISE 3'h3
`define ICC_MODE_RISE4 3'h4
`define ICC_MODE_RISE16 3'h5
`define ICC_MODE_ALT 3'h6
`define ICC_MODE_ANY7 3'h7

// interrupt status bits
`define ICC_IRQ_CAPT 0
`define ICC_IRQ_OVF 1

// axi responses
`define ICC_RESP_OKAY 2'h0
`define ICC_RESP_SLVERR 2'h2

`endif

// [verification/icc_check_sva.sv]
/*
 port checker for the input capture block.
 assumes one clock and that writes offer address and data together.
*/
`timescale 1ns/1ps
`include "icc_defs.vh"
`default_nettype none
module icc_check (
	// clock and reset
	input wire clock,
	input wire rst,
	// register bus
	input wire [11:0] s_axi_awaddr,
	input wire s_axi_awvalid,
	input wire s_axi_awready,
	input wire [31:0] s_axi_wdata,
	input wire [3:0] s_axi_wstrb,
	input wire s_axi_wvalid,
	input wire s_axi_wready,
	input wire s_axi_bvalid,
	input wire s_axi_bready,
	input wire [11:0] s_axi_araddr,
	input wire s_axi_arvalid,
	input wire s_axi_arready,
	input wire [31:0] s_axi_rdata,
	input wire s_axi_rvalid,
	input wire s_axi_rready,
	// interrupt
	input wire irq
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	reg [11:0] rdAddr_ff; // address of the read in flight
	reg en_ff; // enable bit as last written
	// shadow what software asked for
	always @(posedge clock) begin
		if (rst) begin
			rdAddr_ff <= 12'h000;
			en_ff <= 1'b0;
		end else begin
			if (s_axi_arvalid && s_axi_arready)
				rdAddr_ff <= s_axi_araddr;
			// enable lives in byte lane 1; a write without that lane keeps it
			if (s_axi_awvalid && s_axi_awready && s_axi_awaddr == `ICC_OFF_CTRL && s_axi_wstrb[1])
				en_ff <= s_axi_wdata[15];
		end
	end
	////////////////////////////////
	property p_bAns;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid;
	endproperty
	a_bAns: assert property (p_bAns) else $error("no write answer");
	property p_rAns;
		s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
	endproperty
	a_rAns: assert property (p_rAns) else $error("no read answer");
	property p_bDrop;
		s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid;
	endproperty
	a_bDrop: assert property (p_bDrop) else $error("write answer held");
	property p_rDrop;
		s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid;
	endproperty
	a_rDrop: assert property (p_rDrop) else $error("read answer held");
	property p_arBusy;
		s_axi_rvalid |-> !s_axi_arready;
	endproperty
	a_arBusy: assert property (p_arBusy) else $error("read taken while busy");
	property p_hiZero;
		s_axi_rvalid && rdAddr_ff == `ICC_OFF_CTRL |-> (s_axi_rdata & 32'hFFFF5C00) == 32'h0;
	endproperty
	a_hiZero: assert property (p_hiZero) else $error("unused bits set");
	property p_irqOff;
		(!en_ff) [*3] |-> !irq;
	endproperty
	a_irqOff: assert property (p_irqOff) else $error("irq while disabled");
	property p_rstQuiet;
		$fell(rst) |-> !s_axi_bvalid && !s_axi_rvalid && !irq && !s_axi_awready;
	endproperty
	a_rstQuiet: assert property (p_rstQuiet) else $error("busy after reset");
endmodule
bind icc_input_capture icc_check chk0 (.*);
`default_nettype wire

// [verification/icc_pin_model.sv]
/*
 capture pin source. assumes the bench clock; levels change after an edge.
*/
`timescale 1ns/1ps
`default_nettype none
module icc_pin_model (
	// clock and pin
	input wire logic clock,
	output logic pin
);
	initial pin = 1'b0;
	// drive a new level just after an edge
	task drive(input logic v);
		@(posedge clock);
		pin <= v;
	endtask
endmodule
`default_nettype wire

// [verification/input_capture_control_bench.sv]
/*
 bench for the input capture block: bus tasks, pin model, checks.
 assumes 100 MHz clock and synchronous active high reset.
*/
`timescale 1ns/1ps
`include "icc_defs.vh"
`default_nettype none
module input_capture_control_bench;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic idle = 1'b0;
	logic pin;
	logic [11:0] awA = 12'h000;
	logic [11:0] arA = 12'h000;
	logic [31:0] wD = 32'h00000000;
	logic awV = 1'b0, wV = 1'b0, bR = 1'b1, arV = 1'b0, rR = 1'b1; // answers always accepted
	logic [15:0] tTwo = 16'h1234; // narrow timer counts
	logic [15:0] tThree = 16'h5678;
	logic [31:0] tWide = 32'hCAFE0001; // wide timer count
	logic [3:0] strb = 4'hF; // write byte lanes
	wire awRdy, wRdy, bV, arRdy, rV, irq;
	wire [1:0] bRs, rRs;
	wire [31:0] rD;
	logic [1:0] resp;
	logic [31:0] got;
	int n_fail = 0;
	int compares = 0;
	int cyc = 0;
	icc_input_capture dut (.clock(clock), .rst(rst), .capturePin(pin), .deviceIdle(idle),
		.timerTwoCount(tTwo), .timerThreeCount(tThree), .wideTimerCount(tWide),
		.s_axi_awaddr(awA), .s_axi_awvalid(awV), .s_axi_awready(awRdy), .s_axi_wdata(wD),
		.s_axi_wstrb(strb), .s_axi_wvalid(wV), .s_axi_wready(wRdy), .s_axi_bresp(bRs),
		.s_axi_bvalid(bV), .s_axi_bready(bR), .s_axi_araddr(arA), .s_axi_arvalid(arV),
		.s_axi_arready(arRdy), .s_axi_rdata(rD), .s_axi_rresp(rRs), .s_axi_rvalid(rV),
		.s_axi_rready(rR), .irq(irq));
	icc_pin_model pm (.clock(clock), .pin(pin));
	always #5 clock = ~clock;
	// hang guard
	always @(posedge clock) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			n_fail++;
			test_done();
		end
	end
	////////////////////////////////
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			n_fail++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		logic aDn, wDn;
		aDn = 1'b0;
		wDn = 1'b0;
		awA <= a;
		wD <= d;
		awV <= 1'b1;
		wV <= 1'b1;
		while (!(aDn && wDn)) begin
			@(posedge clock);
			aDn = aDn | (awV & awRdy);
			wDn = wDn | (wV & wRdy);
			if (aDn) awV <= 1'b0;
			if (wDn) wV <= 1'b0;
		end
		while (!bV) @(posedge clock);
	endtask
	task rd(input logic [11:0] a, output logic [31:0] d);
		arA <= a;
		arV <= 1'b1;
		do @(posedge clock); while (!arRdy);
		arV <= 1'b0;
		do @(posedge clock); while (!rV);
		d = rD;
		resp = rRs;
	endtask
	task rc(input logic [11:0] a, input logic [31:0] exp);
		rd(a, got);
		chk(got, exp);
	endtask
	// disabling flushes; next access waits a cycle
	task off();
		wr(`ICC_OFF_CTRL, 32'h0);
		@(posedge clock);
	endtask
	task rise();
		pm.drive(1'b1);
		repeat (8) @(posedge clock);
		pm.drive(1'b0);
		repeat (8) @(posedge clock);
	endtask
	task cap(input logic [31:0] c, input logic [31:0] exp);
		wr(`ICC_OFF_CTRL, c);
		rise();
		rc(`ICC_OFF_CTRL, c | 32'h8);
		rc(`ICC_OFF_BUF, exp);
		rc(`ICC_OFF_CTRL, c);
		off();
	endtask
	// prescaled modes: nothing held before the k-th rise
	task cnt(input logic [31:0] c, input int k);
		wr(`ICC_OFF_CTRL, c);
		repeat (k - 1) rise();
		rc(`ICC_OFF_CTRL, c);
		rise();
		rc(`ICC_OFF_CTRL, c | 32'h8);
		off();
	endtask
	// any-edge modes: one pulse gives two captures
	task both(input logic [31:0] c);
		wr(`ICC_OFF_CTRL, c);
		rise();
		rc(`ICC_OFF_BUF, 32'h00005678);
		rc(`ICC_OFF_CTRL, c | 32'h8);
		rc(`ICC_OFF_BUF, 32'h00005678);
		rc(`ICC_OFF_CTRL, c);
		off();
	endtask
	task alt(input logic [31:0] c);
		wr(`ICC_OFF_CTRL, c);
		pm.drive(1'b1);
		repeat (8) @(posedge clock);
		rc(`ICC_OFF_CTRL, c | {28'h0, c[9], 3'h0});
		pm.drive(1'b0);
		repeat (8) @(posedge clock);
		rc(`ICC_OFF_CTRL, c | 32'h8);
		// rise first: the fall is taken too, so one entry stays
		rc(`ICC_OFF_BUF, 32'h00005678);
		rc(`ICC_OFF_CTRL, c | {28'h0, c[9], 3'h0});
		off();
	endtask
	task irqCase(input logic [31:0] c, input int n);
		rd(`ICC_OFF_STAT, got);
		wr(`ICC_OFF_CTRL, c);
		repeat (n - 1) rise();
		chk({31'h0, irq}, 32'h0);
		rise();
		chk({31'h0, irq}, 32'h1);
		rc(`ICC_OFF_STAT, 32'h1);
		repeat (2) @(posedge clock);
		chk({31'h0, irq}, 32'h0);
		off();
	endtask
	task test_done();
		$display("compares %0d mismatches %0d", compares, n_fail);
		if (n_fail == 0 && compares > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask
	////////////////////////////////
	initial begin
		repeat (12) @(posedge clock);
		rst <= 1'b0;
		rc(`ICC_OFF_CTRL, 32'h0);
		wr(`ICC_OFF_CTRL, 32'hFFFFFFFF);
		rc(`ICC_OFF_CTRL, 32'h0000A3E7);
		// low lane only: enable and the upper fields stay
		strb <= 4'h1;
		wr(`ICC_OFF_CTRL, 32'h0);
		strb <= 4'hF;
		rc(`ICC_OFF_CTRL, 32'h0000A300);
		rc(12'h010, 32'h0);
		chk({30'h0, resp}, {30'h0, `ICC_RESP_SLVERR});
		off();
		$display("test registers done");
		cap(32'h00008083, 32'h00001234);
		cap(32'h00008003, 32'h00005678);
		cap(32'h00008183, 32'hCAFE0001);
		tTwo <= 16'h4321;
		tWide <= 32'h13579BDF;
		cap(32'h00008183, 32'h13579BDF);
		cap(32'h00008083, 32'h00004321);
		cap(32'h00008002, 32'h00005678);
		cnt(32'h00008004, 4);
		cnt(32'h00008005, 16);
		both(32'h00008001);
		both(32'h00008007);
		$display("test sources done");
		wr(`ICC_OFF_CTRL, 32'h00008003);
		repeat (5) rise();
		rc(`ICC_OFF_CTRL, 32'h0000801B);
		off();
		rc(`ICC_OFF_CTRL, 32'h0);
		$display("test overflow done");
		alt(32'h00008006);
		alt(32'h00008206);
		$display("test alternate done");
		wr(`ICC_OFF_MASK, 32'h1);
		rc(`ICC_OFF_MASK, 32'h1);
		irqCase(32'h00008003, 2);
		irqCase(32'h00008043, 3);
		irqCase(32'h00008063, 4);
		// masked: status still set, line stays low
		wr(`ICC_OFF_MASK, 32'h0);
		wr(`ICC_OFF_CTRL, 32'h00008003);
		repeat (2) rise();
		chk({31'h0, irq}, 32'h0);
		rc(`ICC_OFF_STAT, 32'h1);
		off();
		$display("test interrupt done");
		idle <= 1'b1;
		wr(`ICC_OFF_CTRL, 32'h0000A003);
		rise();
		rc(`ICC_OFF_CTRL, 32'h0000A003);
		off();
		cap(32'h00008003, 32'h00005678);
		idle <= 1'b0;
		$display("test idle done");
		test_done();
	end
endmodule
`default_nettype wire
